// File: pwr_regs.svh
// Constants for the power-mode and wake-up controller.
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH
`define WAKE_SRC_COUNT 9
`define WAKE_WDT 0
`define WAKE_TMR 1
`define WAKE_UART 2
`define WAKE_USU 3
`define WAKE_BOD 4
`define WAKE_GPIO 5
`define WAKE_EXTERNAL_INTERRUPT 6
`define WAKE_CAN 7
`define WAKE_ANALOG_COMPARATOR 8
`define UART_WAKE_BITS 5
`define CLKSRC_LXT 2'h1
`define CLKSRC_LOW_SPEED_INTERNAL_OSC 2'h2
`define SYNC_STAGES 2
`endif

// File: pwr_pkg.sv
// Types shared by the power-mode and wake-up controller.
package pwr_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_IDLE,
      MODE_PDOWN
   } pwr_mode_e;
   typedef logic [1:0] clk_src_t;
endpackage

// File: wake_flag.sv
// One sticky wake flag with write-1-to-clear; a new event wins over a clear.
`timescale 1ns/1ps
`default_nettype none
module wake_flag (
   input wire logic ref_clk,   // System clock.
   input wire logic srst,      // Synchronous reset, active high.
   input wire logic set_in,    // Wake event, one cycle.
   input wire logic clr_in,    // Write-1-to-clear strobe.
   output logic flag_r         // Sticky flag.
);
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flag_r <= 1'b0;
      end else if (set_in) begin
         flag_r <= 1'b1;
      end else if (clr_in) begin
         flag_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,     // System clock.
   input wire logic srst,        // Synchronous reset, active high.
   input wire logic [W-1:0] d,   // Asynchronous inputs.
   output logic [W-1:0] q        // Synchronised outputs.
);
   logic [W-1:0] meta_r;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// File: power_mode_wakeup_control.sv
// Power-mode manager: normal, idle and power-down modes with wake flags and clock gates.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_regs.svh"
module power_mode_wakeup_control
   import pwr_pkg::*;
(
   input wire logic ref_clk,                     // System clock, 200 MHz.
   input wire logic srst,                        // Synchronous reset, active high.
   input wire logic deep_sleep_select,           // Core deep-sleep setting.
   input wire logic power_down_enable,           // Power-down enable bit.
   input wire logic wfi_pulse,                   // Core executes wait-for-interrupt.
   input wire logic any_irq,                     // Any pending interrupt, same clock.
   input wire logic low_speed_crystal_en,        // Software enable of the low-speed crystal.
   input wire logic low_speed_internal_osc_en,   // Software enable of the internal slow oscillator.
   input wire clk_src_t timer_clk_sel,           // Timer clock source select.
   input wire clk_src_t watchdog_clk_sel,        // Watchdog clock source select.
   input wire clk_src_t uart_clk_sel,            // UART clock source select.
   input wire logic regs_unlocked,               // Write protection lifted.
   input wire logic [`WAKE_SRC_COUNT-1:0] wake_evt_pin,  // Asynchronous wake events from peripherals.
   input wire logic tmr_irq_evt,                 // Timer interrupt event, same clock.
   input wire logic acmp1_wake_evt,              // Second comparator wake event, same clock.
   input wire logic [`UART_WAKE_BITS-1:0] uart_wake_evt,  // UART wake causes, same clock.
   input wire logic clr_bod,                     // Write 1 to brown-out flag.
   input wire logic clr_pin,                     // Write 1 to pin interrupt source flag.
   input wire logic clr_external_interrupt,                    // Write 1 to external interrupt source flag.
   input wire logic clr_tmr_wake,                // Write 1 to timer wake flag.
   input wire logic clr_tmr_irq,                 // Write 1 to timer interrupt flag.
   input wire logic clr_wdt_wake,                // Write 1 to watchdog wake flag.
   input wire logic [`UART_WAKE_BITS-1:0] clr_uart,  // Write 1 to UART wake flags.
   input wire logic clr_usu,                     // Write 1 to serial-unit wake flag.
   input wire logic clr_can,                     // Write 1 to CAN wake flag.
   input wire logic clr_acmp0,                   // Write 1 to comparator 0 wake flag.
   input wire logic clr_acmp1,                   // Write 1 to comparator 1 wake flag.
   output logic [1:0] mode_r,                    // Current mode code.
   output logic cpu_clk_en_r,                    // Processor clock enable.
   output logic bus_clk_en_r,                    // Bus clock enable.
   output logic high_speed_crystal_en_r,         // High-speed crystal run.
   output logic fast_internal_osc_en_r,          // 48 MHz oscillator run.
   output logic low_speed_crystal_on_r,          // Low-speed crystal run.
   output logic low_speed_internal_osc_on_r,     // Internal slow oscillator run.
   output logic main_regulator_on_r,             // Main regulator on.
   output logic standby_regulator_on_r,          // Standby regulator on.
   output logic sram_retain_r,                   // SRAM retention.
   output logic periph_clk_en_r,                 // Flash, GPIO, DMA, PWM, serial unit, ADC, comparator clocks.
   output logic timer_clk_en_r,                  // Timer clock enable.
   output logic watchdog_clk_en_r,               // Watchdog clock enable.
   output logic uart_clk_en_r,                   // UART clock enable.
   output logic window_watchdog_clk_en_r,        // Window watchdog clock enable.
   output logic pd_blocked_r,                    // A wake flag still pending.
   output logic bod_flag_r,                      // Brown-out wake flag.
   output logic pin_interrupt_source_flag_r,     // GPIO pin wake flag.
   output logic external_interrupt_flag_r,                     // External interrupt wake flag.
   output logic timer_wake_flag_r,               // Timer wake flag.
   output logic timer_interrupt_flag_r,          // Timer interrupt flag.
   output logic watchdog_wake_flag_r,            // Watchdog wake flag.
   output logic [`UART_WAKE_BITS-1:0] uart_wake_flags_r,  // CTS, data, FIFO, address, time-out.
   output logic usu_wake_flag_r,                 // Serial-unit wake flag.
   output logic can_wake_flag_r,                 // CAN wake flag.
   output logic comparator0_wake_flag_r,         // Comparator 0 wake flag.
   output logic comparator1_wake_flag_r          // Comparator 1 wake flag.
);
   // ****************************************
   // Wake inputs and sticky flags
   // ****************************************
   logic [`WAKE_SRC_COUNT-1:0] wake_sync;
   logic [`WAKE_SRC_COUNT-1:0] wake_prev_r;
   logic [`WAKE_SRC_COUNT-1:0] wake_rise;
   pwr_mode_e mode_cur_r;
   pwr_mode_e mode_nxt;
   logic wake_req;
   logic lxt_live;
   logic low_speed_internal_osc_live;
   logic pd;

   pin_sync #(.W(`WAKE_SRC_COUNT)) u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .d(wake_evt_pin),
      .q(wake_sync)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wake_prev_r <= '0;
      end else begin
         wake_prev_r <= wake_sync;
      end
   end
   assign wake_rise = wake_sync & ~wake_prev_r;

   wake_flag u_bod (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_BOD]),
      .clr_in(clr_bod), .flag_r(bod_flag_r));
   wake_flag u_pin (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_GPIO]),
      .clr_in(clr_pin), .flag_r(pin_interrupt_source_flag_r));
   wake_flag u_external_interrupt (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_EXTERNAL_INTERRUPT]),
      .clr_in(clr_external_interrupt), .flag_r(external_interrupt_flag_r));
   wake_flag u_twk (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_TMR]),
      .clr_in(clr_tmr_wake), .flag_r(timer_wake_flag_r));
   wake_flag u_tif (.ref_clk(ref_clk), .srst(srst), .set_in(tmr_irq_evt | wake_rise[`WAKE_TMR]),
      .clr_in(clr_tmr_irq), .flag_r(timer_interrupt_flag_r));
   // The watchdog flag sits behind write protection.
   wake_flag u_wdt (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_WDT]),
      .clr_in(clr_wdt_wake & regs_unlocked), .flag_r(watchdog_wake_flag_r));
   wake_flag u_usu (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_USU]),
      .clr_in(clr_usu), .flag_r(usu_wake_flag_r));
   wake_flag u_can (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_CAN]),
      .clr_in(clr_can), .flag_r(can_wake_flag_r));
   wake_flag u_cmp0 (.ref_clk(ref_clk), .srst(srst), .set_in(wake_rise[`WAKE_ANALOG_COMPARATOR]),
      .clr_in(clr_acmp0), .flag_r(comparator0_wake_flag_r));
   wake_flag u_cmp1 (.ref_clk(ref_clk), .srst(srst), .set_in(acmp1_wake_evt),
      .clr_in(clr_acmp1), .flag_r(comparator1_wake_flag_r));

   // Each UART wake cause has its own flag; a rising edge on the UART source pin also sets flag 1, and no other.
   genvar gi;
   generate
      for (gi = 0; gi < `UART_WAKE_BITS; gi = gi + 1) begin : g_uart
         wake_flag u_uf (
            .ref_clk(ref_clk),
            .srst(srst),
            .set_in(uart_wake_evt[gi] | (wake_rise[`WAKE_UART] & (gi == 1))),
            .clr_in(clr_uart[gi]),
            .flag_r(uart_wake_flags_r[gi])
         );
      end
   endgenerate

   // ****************************************
   // Power-mode state machine
   // ****************************************
   // Only the listed peripheral sources count as a power-down wake.
   assign wake_req = |wake_rise | tmr_irq_evt | acmp1_wake_evt | (|uart_wake_evt);

   always_comb begin
      mode_nxt = mode_cur_r;
      case (mode_cur_r)
         MODE_NORMAL: begin
            if (wfi_pulse) begin
               if (deep_sleep_select && power_down_enable && !pd_blocked_r) begin
                  mode_nxt = MODE_PDOWN;
               end else begin
                  mode_nxt = MODE_IDLE;
               end
            end
         end
         MODE_IDLE: begin
            if (any_irq || wake_req) begin
               mode_nxt = MODE_NORMAL;
            end
         end
         MODE_PDOWN: begin
            if (wake_req) begin
               mode_nxt = MODE_NORMAL;
            end
         end
         default: mode_nxt = MODE_NORMAL;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_cur_r <= MODE_NORMAL;
      end else begin
         mode_cur_r <= mode_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pd_blocked_r <= 1'b0;
      end else begin
         pd_blocked_r <= bod_flag_r | pin_interrupt_source_flag_r | external_interrupt_flag_r | timer_wake_flag_r
            | timer_interrupt_flag_r | watchdog_wake_flag_r | (|uart_wake_flags_r) | usu_wake_flag_r
            | can_wake_flag_r | comparator0_wake_flag_r | comparator1_wake_flag_r;
      end
   end

   // ****************************************
   // Clock and power gating
   // ****************************************
   assign pd = (mode_nxt == MODE_PDOWN);
   assign lxt_live = low_speed_crystal_en;
   assign low_speed_internal_osc_live = low_speed_internal_osc_en;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_r <= 2'h0;
         cpu_clk_en_r <= 1'b1;
         bus_clk_en_r <= 1'b1;
         high_speed_crystal_en_r <= 1'b1;
         fast_internal_osc_en_r <= 1'b1;
         main_regulator_on_r <= 1'b1;
         standby_regulator_on_r <= 1'b1;
         sram_retain_r <= 1'b1;
         periph_clk_en_r <= 1'b1;
         window_watchdog_clk_en_r <= 1'b1;
      end else begin
         mode_r <= mode_nxt;
         cpu_clk_en_r <= (mode_nxt == MODE_NORMAL);
         bus_clk_en_r <= !pd;
         high_speed_crystal_en_r <= !pd;
         fast_internal_osc_en_r <= !pd;
         main_regulator_on_r <= !pd;
         standby_regulator_on_r <= 1'b1;
         sram_retain_r <= 1'b1;
         periph_clk_en_r <= !pd;
         window_watchdog_clk_en_r <= (mode_nxt == MODE_NORMAL);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         low_speed_crystal_on_r <= 1'b1;
         low_speed_internal_osc_on_r <= 1'b1;
         timer_clk_en_r <= 1'b1;
         watchdog_clk_en_r <= 1'b1;
         uart_clk_en_r <= 1'b1;
      end else if (pd) begin
         low_speed_crystal_on_r <= lxt_live;
         low_speed_internal_osc_on_r <= low_speed_internal_osc_live;
         timer_clk_en_r <= ((timer_clk_sel == `CLKSRC_LXT) && lxt_live)
            || ((timer_clk_sel == `CLKSRC_LOW_SPEED_INTERNAL_OSC) && low_speed_internal_osc_live);
         watchdog_clk_en_r <= (watchdog_clk_sel == `CLKSRC_LOW_SPEED_INTERNAL_OSC) && low_speed_internal_osc_live;
         uart_clk_en_r <= (uart_clk_sel == `CLKSRC_LXT) && lxt_live;
      end else begin
         low_speed_crystal_on_r <= 1'b1;
         low_speed_internal_osc_on_r <= 1'b1;
         timer_clk_en_r <= 1'b1;
         watchdog_clk_en_r <= 1'b1;
         uart_clk_en_r <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: pwr_mode_monitor.sv
// Concurrent checks on the ports of the power-mode and wake-up controller.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_regs.svh"
module pwr_mode_monitor
   import pwr_pkg::*;
(
   input wire logic ref_clk, // Clock.
   input wire logic srst, // Reset.
   input wire logic deep_sleep_select, // Deep sleep.
   input wire logic power_down_enable, // Power-down enable.
   input wire logic wfi_pulse, // Wait-for-interrupt.
   input wire logic any_irq, // Interrupt.
   input wire clk_src_t timer_clk_sel, // Timer source.
   input wire clk_src_t watchdog_clk_sel, // Watchdog source.
   input wire clk_src_t uart_clk_sel, // UART source.
   input wire logic regs_unlocked, // Unlocked.
   input wire logic clr_wdt_wake, // Watchdog clear.
   input wire logic [1:0] mode_r, // Mode.
   input wire logic cpu_clk_en_r, // CPU clock.
   input wire logic bus_clk_en_r, // Bus clock.
   input wire logic low_speed_crystal_on_r, // Slow crystal.
   input wire logic low_speed_internal_osc_on_r, // Slow oscillator.
   input wire logic main_regulator_on_r, // Main regulator.
   input wire logic standby_regulator_on_r, // Standby regulator.
   input wire logic sram_retain_r, // Retention.
   input wire logic periph_clk_en_r, // Peripheral clocks.
   input wire logic timer_clk_en_r, // Timer clock.
   input wire logic watchdog_clk_en_r, // Watchdog clock.
   input wire logic uart_clk_en_r, // UART clock.
   input wire logic window_watchdog_clk_en_r, // Window watchdog clock.
   input wire logic pd_blocked_r, // Pending wake.
   input wire logic timer_wake_flag_r, // Timer wake.
   input wire logic timer_interrupt_flag_r, // Timer interrupt.
   input wire logic watchdog_wake_flag_r // Watchdog wake.
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   rst_mode_a: assert property ($fell(srst) |-> mode_r == 2'h0 && cpu_clk_en_r)
      else $error("mode not normal after reset");
   pd_entry_a: assert property (mode_r == 2'h0 && wfi_pulse && deep_sleep_select && power_down_enable && !pd_blocked_r
      |=> mode_r == 2'h2)
      else $error("power-down not entered");
   idle_entry_a: assert property (mode_r == 2'h0 && wfi_pulse && !(deep_sleep_select && power_down_enable)
      |=> mode_r == 2'h1)
      else $error("idle not entered");
   idle_gate_a: assert property (mode_r == 2'h1 |-> !cpu_clk_en_r && bus_clk_en_r && periph_clk_en_r)
      else $error("idle gating wrong");
   pd_gate_a: assert property (mode_r == 2'h2 |-> !(cpu_clk_en_r || bus_clk_en_r || periph_clk_en_r ||
      main_regulator_on_r) && standby_regulator_on_r && sram_retain_r)
      else $error("power-down gating wrong");
   pd_source_a: assert property (mode_r == 2'h2 |-> timer_clk_en_r == ((timer_clk_sel == `CLKSRC_LXT &&
      low_speed_crystal_on_r) || (timer_clk_sel == `CLKSRC_LOW_SPEED_INTERNAL_OSC && low_speed_internal_osc_on_r)) &&
      watchdog_clk_en_r == (watchdog_clk_sel == `CLKSRC_LOW_SPEED_INTERNAL_OSC && low_speed_internal_osc_on_r) &&
      uart_clk_en_r == (uart_clk_sel == `CLKSRC_LXT && low_speed_crystal_on_r))
      else $error("slow peripheral clock wrong");
   window_dog_a: assert property (mode_r != 2'h0 |-> !window_watchdog_clk_en_r)
      else $error("window watchdog runs in low power");
   idle_wake_a: assert property (mode_r == 2'h1 && any_irq |=> mode_r == 2'h0)
      else $error("interrupt did not wake idle");
   timer_pair_a: assert property ($rose(timer_wake_flag_r) |-> timer_interrupt_flag_r)
      else $error("timer wake without interrupt flag");
   wdt_lock_a: assert property (watchdog_wake_flag_r && clr_wdt_wake && !regs_unlocked
      |=> watchdog_wake_flag_r)
      else $error("locked watchdog flag cleared");
   cover property (mode_r == 2'h2 ##1 mode_r == 2'h0);
   cover property (mode_r == 2'h1 ##1 mode_r == 2'h0);
   cover property (watchdog_wake_flag_r && clr_wdt_wake && !regs_unlocked);
endmodule
bind power_mode_wakeup_control pwr_mode_monitor u_mon (.*);
`default_nettype wire

// File: core_periph_model.sv
// Model of the processor core and the wake-capable peripherals.
`timescale 1ns/1ps
`default_nettype none
module core_periph_model (
   input wire logic ref_clk, // System clock.
   output logic wfi_pulse, // Wait-for-interrupt pulse.
   output logic any_irq, // Pending interrupt.
   output logic [8:0] wake_evt_pin // Wake lines.
);
   initial begin
      wfi_pulse = 1'b0;
      any_irq = 1'b0;
      wake_evt_pin = 9'h000;
   end
   task automatic wfi();
      @(negedge ref_clk) wfi_pulse = 1'b1;
      @(negedge ref_clk) wfi_pulse = 1'b0;
   endtask
   task automatic irq();
      @(negedge ref_clk) any_irq = 1'b1;
      @(negedge ref_clk) any_irq = 1'b0;
   endtask
   // The line is held well past the synchroniser so the edge is seen.
   task automatic wake(input int i);
      @(negedge ref_clk) wake_evt_pin[i] = 1'b1;
      repeat (6) @(negedge ref_clk);
      wake_evt_pin[i] = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: power_mode_wakeup_control_tb_top.sv
// Self-checking testbench for the power-mode and wake-up controller.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
`define CLRS {clr_acmp1, clr_acmp0, clr_can, clr_usu, clr_uart, clr_wdt_wake, clr_tmr_irq, clr_tmr_wake, clr_external_interrupt, clr_pin, clr_bod}
module power_mode_wakeup_control_tb_top
   import pwr_pkg::*;
;
   logic ref_clk = 1'b0;
   logic srst, deep_sleep_select, power_down_enable, low_speed_crystal_en, low_speed_internal_osc_en;
   logic regs_unlocked, tmr_irq_evt, acmp1_wake_evt, clr_bod, clr_pin, clr_external_interrupt, clr_tmr_wake, clr_tmr_irq;
   logic clr_wdt_wake, clr_usu, clr_can, clr_acmp0, clr_acmp1, wfi_pulse, any_irq;
   logic [4:0] uart_wake_evt, clr_uart, uart_wake_flags_r;
   logic [8:0] wake_evt_pin, fl;
   clk_src_t timer_clk_sel, watchdog_clk_sel, uart_clk_sel;
   logic [1:0] mode_r;
   logic cpu_clk_en_r, bus_clk_en_r, high_speed_crystal_en_r, fast_internal_osc_en_r, low_speed_crystal_on_r;
   logic low_speed_internal_osc_on_r, main_regulator_on_r, standby_regulator_on_r, sram_retain_r;
   logic periph_clk_en_r, timer_clk_en_r, watchdog_clk_en_r, uart_clk_en_r, window_watchdog_clk_en_r;
   logic pd_blocked_r, bod_flag_r, pin_interrupt_source_flag_r, external_interrupt_flag_r, timer_wake_flag_r;
   logic timer_interrupt_flag_r, watchdog_wake_flag_r, usu_wake_flag_r, can_wake_flag_r;
   logic comparator0_wake_flag_r, comparator1_wake_flag_r;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   assign fl = {comparator0_wake_flag_r, can_wake_flag_r, external_interrupt_flag_r, pin_interrupt_source_flag_r, bod_flag_r,
      usu_wake_flag_r, uart_wake_flags_r[1], timer_wake_flag_r, watchdog_wake_flag_r};
   power_mode_wakeup_control u_dut (.*);
   core_periph_model u_core (.*);
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Software clear: one-cycle write-1 strobes.
   task automatic pulse_clr(input logic [14:0] m);
      @(negedge ref_clk) `CLRS = m;
      @(negedge ref_clk) `CLRS = 15'h0000;
   endtask
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      srst = 1'b1;
      {deep_sleep_select, power_down_enable, regs_unlocked, tmr_irq_evt, acmp1_wake_evt, uart_wake_evt} = 10'h000;
      `CLRS = 15'h0000;
      {low_speed_crystal_en, low_speed_internal_osc_en} = 2'h3;
      {timer_clk_sel, watchdog_clk_sel, uart_clk_sel} = {`CLKSRC_LXT, `CLKSRC_LOW_SPEED_INTERNAL_OSC, `CLKSRC_LXT};
      repeat (20) @(negedge ref_clk);
      srst = 1'b0;
      @(negedge ref_clk);
      `CHK({mode_r, cpu_clk_en_r, window_watchdog_clk_en_r, pd_blocked_r}, 5'h06)
      $display("Test reset done");
      for (int k = 0; k < 3; k++) begin
         {deep_sleep_select, power_down_enable} = k[1:0];
         u_core.wfi();
         `CHK({mode_r, cpu_clk_en_r, bus_clk_en_r, periph_clk_en_r, window_watchdog_clk_en_r}, 6'h16)
         u_core.irq();
         `CHK(mode_r, 2'h0)
      end
      $display("Test idle done");
      {deep_sleep_select, power_down_enable} = 2'h3;
      for (int i = 0; i < 9; i++) begin
         low_speed_internal_osc_en = i[0];
         regs_unlocked = 1'b0;
         u_core.wfi();
         `CHK({mode_r, cpu_clk_en_r, bus_clk_en_r, periph_clk_en_r, main_regulator_on_r, high_speed_crystal_en_r,
            fast_internal_osc_en_r}, 8'h80)
         `CHK({standby_regulator_on_r, sram_retain_r, low_speed_crystal_on_r, low_speed_internal_osc_on_r,
            watchdog_clk_en_r, timer_clk_en_r, uart_clk_en_r}, {3'h7, {2{i[0]}}, 2'h3})
         u_core.wake(i);
         `CHK(mode_r, 2'h0)
         `CHK({fl, pd_blocked_r, timer_interrupt_flag_r}, {9'h001 << i, 1'b1, i == 1})
         u_core.wfi();
         `CHK(mode_r, 2'h1)
         u_core.irq();
         pulse_clr(15'h0028);
         `CHK({watchdog_wake_flag_r, timer_interrupt_flag_r, timer_wake_flag_r}, {i == 0, i == 1, 1'b0})
         regs_unlocked = 1'b1;
         pulse_clr(15'h7FFF);
         repeat (2) @(negedge ref_clk);
         `CHK({fl, pd_blocked_r, timer_interrupt_flag_r}, 11'h000)
      end
      $display("Test power-down wake done");
      {deep_sleep_select, power_down_enable} = 2'h0;
      u_core.wfi();
      `CHK(mode_r, 2'h1)
      u_core.wake(3);
      `CHK({mode_r, cpu_clk_en_r, usu_wake_flag_r}, 4'h3)
      pulse_clr(15'h0800);
      `CHK(usu_wake_flag_r, 1'b0)
      $display("Test idle wake done");
      @(negedge ref_clk) {uart_wake_evt, tmr_irq_evt, acmp1_wake_evt} = 7'h7F;
      @(negedge ref_clk) {uart_wake_evt, tmr_irq_evt, acmp1_wake_evt} = 7'h00;
      `CHK({uart_wake_flags_r, comparator1_wake_flag_r, timer_interrupt_flag_r}, 7'h7F)
      pulse_clr(15'h0540);
      `CHK(uart_wake_flags_r, 5'h0A)
      pulse_clr(15'h4010);
      `CHK({comparator1_wake_flag_r, timer_interrupt_flag_r, comparator0_wake_flag_r}, 3'h0)
      $display("Test flag clear done");
      report_and_stop();
   end
endmodule
`default_nettype wire
